// ### hw/abu_defines.vh
`ifndef ABU_DEFINES_VH
`define ABU_DEFINES_VH
// Register offsets on the special function register bus
`define ABU_MEMCTL_ADDR 8'h95
`define ABU_BPCTL_ADDR 8'hA9
`define ABU_BPLO_ADDR 8'hAA
`define ABU_BPHI_ADDR 8'hAB
`define ABU_AIE_ADDR 8'hA6
`define ABU_AUX_INT_STATUS_REG_ADDR 8'hA7
`define ABU_EXTENDED_INT_CONTROL_REG_ADDR 8'hD8
// Field positions
`define ABU_SLOT_BIT 7
`define ABU_ONCHIP_RAM_PLACEMENT_BIT 0
`define ABU_PEND_BIT 7
`define ABU_SPACE_BIT 1
`define ABU_EN_BIT 0
`define ABU_LVB_EN_BIT 0
`define ABU_LVB_STAT_BIT 0
`define ABU_AUX_EN_BIT 5
`define ABU_AUX_FLAG_BIT 4
// Reset values
`define ABU_MEMCTL_RST 8'h00
`define ABU_BPCTL_RST 8'h00
`define ABU_ADDR_RST 16'h0000
// Interrupt vector and priority
`define ABU_INT_VECTOR 8'h33
`define ABU_INT_PRIO 4'h0
// RAM placement windows
`define ABU_RAM_LO_BASE 16'h0000
`define ABU_RAM_LO_TOP 16'h03FF
`define ABU_RAM_HI_BASE 16'h8400
`define ABU_RAM_HI_TOP 16'h87FF
`endif

// ### hw/abu_breakpoint_unit.v
// What this block does
// - Two slots of 16-bit address; enabled slot match requests an interrupt.
// - Space-select per selected slot: 1 program memory, 0 external data memory.
// - Writing memory control bit 7 selects slot 0 or 1 for later accesses.
// - Reading memory control bit 7 returns slot that fired last.
// - Bit 0 places RAM low at 0000-03FF or shared at 8400-87FF.
// - Writing 1 to control bit 7 clears selected slot pending; 0 ignored.
// - Reading pending bit gives 1 when either slot has a pending match.
// - Control bit 0 enables match interrupt for the selected slot only.
// - Low address register accesses bits 7..0 of selected slot address.
// - High address register accesses bits 15..8 of selected slot address.
// - Interrupt is priority 0 and vectors to 33h, shared with low voltage.
// - Request reaches core only with aux enable and combined enable both set.
// - Breakpoint match is shown in combined status bit 0 of aux status while combined enable is set.
// - Interrupt may follow the match by a few instruction cycles.
// - Prefetch accesses are compared too, so false hits are possible.
`timescale 1ns/1ps
`default_nettype none
`include "abu_defines.vh"
module abu_breakpoint_unit #(
	parameter AW = 16
) (
	input wire clk, // Core clock
	input wire nrst, // Synchronous reset, active low
	input wire [7:0] sfr_addr, // Special function register address
	input wire [7:0] sfr_wdata, // Write data
	input wire sfr_wr, // Write strobe
	input wire sfr_rd, // Read strobe
	output reg [7:0] sfr_rdata, // Read data
	output wire sfr_hit, // Address belongs to this block
	input wire [AW-1:0] mem_addr, // Access address, prefetch included
	input wire mem_valid, // Access strobe
	input wire mem_is_code, // 1 code space, 0 external data
	input wire lowvolt_irq, // Digital low-voltage detect event level
	output wire int_req, // Interrupt request to core
	output wire [7:0] int_vector, // Vector for the request
	output wire [3:0] int_prio, // Priority level of the request
	output wire onchip_ram_placement, // RAM map select
	output wire ram_sel // Current data access lands in on-chip RAM
);
	// Slot selection and memory map
	reg sel_r; // Slot chosen by writes
	reg sel_nxt; // Next slot choice
	reg last_r; // Slot that fired last
	reg last_nxt; // Next fired-slot record
	reg onchip_ram_placement_r; // RAM placement bit
	reg onchip_ram_placement_nxt; // Next RAM placement

	// Per-slot state, index is the slot number
	reg [1:0] space_r; // 1 code, 0 external data
	reg [1:0] space_nxt; // Next space choice
	reg [1:0] en_r; // Match enables
	reg [1:0] en_nxt; // Next match enables
	reg [1:0] pend_r; // Pending matches
	reg [1:0] pend_nxt; // Next pending matches
	reg [AW-1:0] bp0_r; // Slot 0 compare address
	reg [AW-1:0] bp0_nxt; // Next slot 0 address
	reg [AW-1:0] bp1_r; // Slot 1 compare address
	reg [AW-1:0] bp1_nxt; // Next slot 1 address

	// Enables of the shared auxiliary request
	reg aux_en_r; // Auxiliary interrupt enable
	reg aux_en_nxt; // Next auxiliary enable
	reg lvb_en_r; // Low-voltage-or-breakpoint enable
	reg lvb_en_nxt; // Next combined enable

	// Read path
	reg [7:0] rdata_nxt; // Value a read would capture

	// Decoded strobes and status
	wire [1:0] hit; // Per-slot match this cycle
	wire wr_mem; // Write to memory control
	wire wr_bp; // Write to breakpoint control
	wire wr_lo; // Write to low address byte
	wire wr_hi; // Write to high address byte
	wire wr_aie; // Write to aux enable register
	wire wr_eic; // Write to extended control
	wire clr_req; // Write of 1 to the pending bit
	wire lvb_stat; // Combined status bit
	wire aux_flag; // Auxiliary flag, gated
	wire [AW-1:0] sel_addr; // Address of the selected slot

	// Slot compare against one access
	function slot_match;
		input [AW-1:0] a;
		input [AW-1:0] bp;
		input en;
		input space;
		input code;
		begin
			slot_match = en & (a == bp) & (space == code);
		end
	endfunction

	// Replace one byte of a slot address; hi picks bits 15..8
	function [AW-1:0] put_byte;
		input [AW-1:0] old;
		input [7:0] b;
		input hi;
		begin
			put_byte = old;
			if (hi) begin
				put_byte[15:8] = b;
			end else begin
				put_byte[7:0] = b;
			end
		end
	endfunction

	// Address decode
	assign wr_mem = sfr_wr & (sfr_addr == `ABU_MEMCTL_ADDR);
	assign wr_bp = sfr_wr & (sfr_addr == `ABU_BPCTL_ADDR);
	assign wr_lo = sfr_wr & (sfr_addr == `ABU_BPLO_ADDR);
	assign wr_hi = sfr_wr & (sfr_addr == `ABU_BPHI_ADDR);
	assign wr_aie = sfr_wr & (sfr_addr == `ABU_AIE_ADDR);
	assign wr_eic = sfr_wr & (sfr_addr == `ABU_EXTENDED_INT_CONTROL_REG_ADDR);
	assign clr_req = wr_bp & sfr_wdata[`ABU_PEND_BIT];
	assign sfr_hit = (sfr_addr == `ABU_MEMCTL_ADDR) | (sfr_addr == `ABU_BPCTL_ADDR) |
		(sfr_addr == `ABU_BPLO_ADDR) | (sfr_addr == `ABU_BPHI_ADDR) |
		(sfr_addr == `ABU_AIE_ADDR) | (sfr_addr == `ABU_AUX_INT_STATUS_REG_ADDR) |
		(sfr_addr == `ABU_EXTENDED_INT_CONTROL_REG_ADDR);
	assign sel_addr = sel_r ? bp1_r : bp0_r;

	// Comparators see every access, prefetch too
	assign hit[0] = mem_valid & slot_match(mem_addr, bp0_r, en_r[0], space_r[0], mem_is_code);
	assign hit[1] = mem_valid & slot_match(mem_addr, bp1_r, en_r[1], space_r[1], mem_is_code);

	// Slot select and RAM placement take bits 7 and 0 of every memory control write
	always @* begin
		sel_nxt = sel_r;
		onchip_ram_placement_nxt = onchip_ram_placement_r;
		if (wr_mem) begin
			sel_nxt = sfr_wdata[`ABU_SLOT_BIT];
			onchip_ram_placement_nxt = sfr_wdata[`ABU_ONCHIP_RAM_PLACEMENT_BIT];
		end
	end

	// Space and enable land in the selected slot only
	always @* begin
		space_nxt = space_r;
		en_nxt = en_r;
		if (wr_bp) begin
			space_nxt[sel_r] = sfr_wdata[`ABU_SPACE_BIT];
			en_nxt[sel_r] = sfr_wdata[`ABU_EN_BIT];
		end
	end

	// Address bytes go to the selected slot, each byte on its own
	always @* begin
		bp0_nxt = bp0_r;
		bp1_nxt = bp1_r;
		if (wr_lo & ~sel_r) begin
			bp0_nxt = put_byte(bp0_r, sfr_wdata, 1'b0);
		end
		if (wr_lo & sel_r) begin
			bp1_nxt = put_byte(bp1_r, sfr_wdata, 1'b0);
		end
		if (wr_hi & ~sel_r) begin
			bp0_nxt = put_byte(bp0_r, sfr_wdata, 1'b1);
		end
		if (wr_hi & sel_r) begin
			bp1_nxt = put_byte(bp1_r, sfr_wdata, 1'b1);
		end
	end

	// Enables of the shared request, one bit in each register
	always @* begin
		lvb_en_nxt = lvb_en_r;
		aux_en_nxt = aux_en_r;
		if (wr_aie) begin
			lvb_en_nxt = sfr_wdata[`ABU_LVB_EN_BIT];
		end
		if (wr_eic) begin
			aux_en_nxt = sfr_wdata[`ABU_AUX_EN_BIT];
		end
	end

	// Pending flags: a new hit wins over a clear in the same cycle
	always @* begin
		pend_nxt = pend_r;
		last_nxt = last_r;
		if (clr_req) begin
			pend_nxt[sel_r] = 1'b0;
		end
		if (hit[0]) begin
			pend_nxt[0] = 1'b1;
			last_nxt = 1'b0;
		end
		if (hit[1]) begin
			pend_nxt[1] = 1'b1;
			last_nxt = 1'b1;
		end
	end

	// Control registers: selection, map, enables, pending
	always @(posedge clk) begin
		if (!nrst) begin
			sel_r <= 1'b0;
			last_r <= 1'b0;
			onchip_ram_placement_r <= 1'b0;
			space_r <= 2'h0;
			en_r <= 2'h0;
			pend_r <= 2'h0;
			aux_en_r <= 1'b0;
			lvb_en_r <= 1'b0;
		end else begin
			sel_r <= sel_nxt;
			last_r <= last_nxt;
			onchip_ram_placement_r <= onchip_ram_placement_nxt;
			space_r <= space_nxt;
			en_r <= en_nxt;
			pend_r <= pend_nxt;
			aux_en_r <= aux_en_nxt;
			lvb_en_r <= lvb_en_nxt;
		end
	end

	// Slot compare addresses
	always @(posedge clk) begin
		if (!nrst) begin
			bp0_r <= `ABU_ADDR_RST;
			bp1_r <= `ABU_ADDR_RST;
		end else begin
			bp0_r <= bp0_nxt;
			bp1_r <= bp1_nxt;
		end
	end

	// Interrupt path; latency of a few cycles is acceptable
	assign lvb_stat = lvb_en_r & ((|pend_r) | lowvolt_irq);
	assign aux_flag = aux_en_r & lvb_stat;
	assign int_req = aux_flag;
	assign int_vector = `ABU_INT_VECTOR;
	assign int_prio = `ABU_INT_PRIO;

	// RAM placement decode for data accesses
	assign onchip_ram_placement = onchip_ram_placement_r;
	assign ram_sel = onchip_ram_placement_r ?
		((mem_addr >= `ABU_RAM_HI_BASE) & (mem_addr <= `ABU_RAM_HI_TOP)) :
		(~mem_is_code & (mem_addr <= `ABU_RAM_LO_TOP));

	// Read multiplexer; unmapped addresses read as zero
	always @* begin
		rdata_nxt = 8'h00;
		if (sfr_addr == `ABU_MEMCTL_ADDR) begin
			rdata_nxt = {last_r, 6'h00, onchip_ram_placement_r};
		end else if (sfr_addr == `ABU_BPCTL_ADDR) begin
			rdata_nxt = {|pend_r, 5'h00, space_r[sel_r], en_r[sel_r]};
		end else if (sfr_addr == `ABU_BPLO_ADDR) begin
			rdata_nxt = sel_addr[7:0];
		end else if (sfr_addr == `ABU_BPHI_ADDR) begin
			rdata_nxt = sel_addr[15:8];
		end else if (sfr_addr == `ABU_AIE_ADDR) begin
			rdata_nxt = {7'h00, lvb_en_r};
		end else if (sfr_addr == `ABU_AUX_INT_STATUS_REG_ADDR) begin
			rdata_nxt = {7'h00, lvb_stat};
		end else if (sfr_addr == `ABU_EXTENDED_INT_CONTROL_REG_ADDR) begin
			rdata_nxt = {2'h0, aux_en_r, aux_flag, 4'h0};
		end else begin
			rdata_nxt = 8'h00;
		end
	end

	// Read data register; holds its value between reads
	always @(posedge clk) begin
		if (!nrst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= rdata_nxt;
		end
	end

endmodule // abu_breakpoint_unit
`default_nettype wire

// ### sim/abu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module abu_core_model (
	input wire logic clk, // Core clock
	input wire logic go, // Issue one access
	input wire logic [15:0] a, // Access address
	input wire logic code, // Code space access
	output logic mem_valid, // Access strobe
	output logic [15:0] mem_addr, // Bus address
	output logic mem_is_code // Space of access
);
	initial mem_addr = 16'h0000;
	// One-cycle access, fetch or prefetch alike; idle bus shows the inverse address
	always @(posedge clk) begin
		mem_valid <= go;
		mem_addr <= go ? a : ~mem_addr;
		mem_is_code <= code;
	end
endmodule // abu_core_model
`default_nettype wire

// ### sim/abu_breakpoint_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
module abu_breakpoint_unit_chk #(parameter AW = 16) (
	input wire logic clk, // Core clock
	input wire logic nrst, // Reset, active low
	input wire logic sfr_wr, // Write strobe
	input wire logic sfr_rd, // Read strobe
	input wire logic sfr_hit, // Register address hit
	input wire logic mem_is_code, // Access space
	input wire logic lowvolt_irq, // Low-voltage event
	input wire logic int_req, // Interrupt request
	input wire logic onchip_ram_placement, // RAM map bit
	input wire logic ram_sel, // RAM select
	input wire logic [7:0] sfr_addr, // Register address
	input wire logic [7:0] sfr_wdata, // Write data
	input wire logic [7:0] sfr_rdata, // Read data
	input wire logic [7:0] int_vector, // Request vector
	input wire logic [3:0] int_prio, // Request priority
	input wire logic [AW-1:0] mem_addr // Access address
);
	logic aie_r, eai_r;
	// Shadow of the two request enables
	always @(posedge clk) begin
		if (!nrst || (sfr_wr && sfr_addr == 8'hA6)) aie_r <= nrst & sfr_wdata[0];
		if (!nrst || (sfr_wr && sfr_addr == 8'hD8)) eai_r <= nrst & sfr_wdata[5];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_int_const: assert property (int_vector == 8'h33 && int_prio == 4'h0)
		else $error("bad vector");
	a_req_gated: assert property (int_req |-> aie_r && eai_r)
		else $error("ungated request");
	a_req_holds: assert property (int_req && !lowvolt_irq && !sfr_wr |=> int_req)
		else $error("request lost");
	a_flag_read: assert property (sfr_rd && sfr_addr == 8'hD8 |=> sfr_rdata[4] == $past(int_req))
		else $error("flag read");
	a_bpctl_zero: assert property (sfr_rd && sfr_addr == 8'hA9 |=> sfr_rdata[6:2] == 5'h00)
		else $error("reserved bits");
	a_unmapped_read: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
		else $error("unmapped read");
	a_rdata_hold: assert property ($past(nrst) && !$past(sfr_rd) |-> $stable(sfr_rdata))
		else $error("read data moved");
	a_ram_low: assert property (!onchip_ram_placement |-> ram_sel == (!mem_is_code && mem_addr <= 16'h03FF))
		else $error("low ram map");
	a_ram_high: assert property (onchip_ram_placement && mem_addr[15:10] == 6'h21 |-> ram_sel)
		else $error("high ram map");
	cover property (int_req);
	cover property (sfr_rd && sfr_addr == 8'hA9);
	cover property (onchip_ram_placement && ram_sel);
endmodule // abu_breakpoint_unit_chk
bind abu_breakpoint_unit abu_breakpoint_unit_chk #(.AW(AW)) u_chk (.*);
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define C(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED %0t mismatch", $time); end end
module tb;
	logic clk = 1'h0, nrst = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0, go = 1'h0, mc = 1'h0, rs;
	logic lv = 1'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
	logic [15:0] ma = 16'h0000;
	wire [15:0] mem_addr;
	wire [7:0] sfr_rdata;
	wire mem_valid, mem_is_code, int_req, ram_sel, onchip_ram_placement;
	int error_cnt = 0, checks = 0;
	always #10 clk = ~clk;
	abu_breakpoint_unit u_abu_breakpoint_unit (.clk, .nrst, .sfr_addr, .sfr_wdata, .sfr_wr,
		.sfr_rd, .sfr_rdata, .sfr_hit(), .mem_addr, .mem_valid, .mem_is_code, .lowvolt_irq(lv),
		.int_req, .int_vector(), .int_prio(), .onchip_ram_placement, .ram_sel);
	abu_core_model u_abu_core_model (.clk, .go, .a(ma), .code(mc), .mem_valid, .mem_addr,
		.mem_is_code);
	task end_sim;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Register write, settled one step after the taking edge
	task wr(input logic [7:0] a, d);
		@(posedge clk);
		{sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'h1};
		@(posedge clk);
		sfr_wr <= 1'h0;
		#1;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge clk);
		{sfr_addr, sfr_rd} <= {a, 1'h1};
		@(posedge clk);
		sfr_rd <= 1'h0;
		#1 `C(sfr_rdata, e)
	endtask
	// One memory access through the core model; ram_sel captured on the bus
	task acc(input logic [15:0] a, input logic c);
		@(posedge clk);
		{ma, mc, go} <= {a, c, 1'h1};
		@(posedge clk);
		go <= 1'h0;
		#1 rs = ram_sel;
		@(posedge clk);
		#1;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		end_sim;
	end
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		rd(8'hA9, 8'h00);
		wr(8'h95, 8'h80);
		wr(8'hAA, 8'h34);
		wr(8'hAB, 8'h12);
		rd(8'hAA, 8'h34);
		rd(8'hAB, 8'h12);
		wr(8'hA9, 8'h03);
		wr(8'h95, 8'h00);
		rd(8'hAB, 8'h00);
		wr(8'hAA, 8'h78);
		wr(8'hAB, 8'h56);
		wr(8'hA9, 8'h01);
		wr(8'hA6, 8'h01);
		wr(8'hD8, 8'h20);
		acc(16'h1234, 1'h0);
		`C(int_req, 1'h0)
		acc(16'h1234, 1'h1);
		`C(int_req, 1'h1)
		rd(8'h95, 8'h80);
		rd(8'hA9, 8'h81);
		rd(8'hD8, 8'h30);
		rd(8'hA7, 8'h01);
		wr(8'hA9, 8'h81);
		`C(int_req, 1'h1)
		wr(8'h95, 8'h80);
		wr(8'hA9, 8'h03);
		`C(int_req, 1'h1)
		wr(8'hA9, 8'h83);
		`C(int_req, 1'h0)
		$display("slot one test done");
		acc(16'h5678, 1'h1);
		`C(int_req, 1'h0)
		acc(16'h5678, 1'h0);
		`C(int_req, 1'h1)
		rd(8'h95, 8'h00);
		wr(8'h95, 8'h00);
		wr(8'hA9, 8'h80);
		acc(16'h5678, 1'h0);
		`C(int_req, 1'h0)
		rd(8'h00, 8'h00);
		$display("slot zero test done");
		wr(8'h95, 8'h01);
		`C(onchip_ram_placement, 1'h1)
		acc(16'h8400, 1'h1);
		`C(rs, 1'h1)
		acc(16'h03FF, 1'h0);
		`C(rs, 1'h0)
		$display("ram map test done");
		@(posedge clk);
		lv <= 1'h1;
		#1 `C(int_req, 1'h1)
		rd(8'hA7, 8'h01);
		wr(8'hA6, 8'h00);
		`C(int_req, 1'h0)
		@(posedge clk);
		lv <= 1'h0;
		$display("low voltage test done");
		end_sim;
	end
endmodule // tb
`default_nettype wire
